// file: common/bidl_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the binary I/O block.
  Assumes a 125 MHz device clock and a byte-addressed register port of eight bits.
*/
`ifndef BIDL_CONSTS_SVH
`define BIDL_CONSTS_SVH

`define BIDL_CLK_MHZ        125
`define BIDL_TICK_US        1000
`define BIDL_TICK_CYC       (`BIDL_TICK_US * `BIDL_CLK_MHZ)
`define BIDL_STAB_MS        12
`define BIDL_STAB_TICKS     4'((`BIDL_STAB_MS * 1000 + `BIDL_TICK_US - 1) / `BIDL_TICK_US)

`define BIDL_N_IN           8
`define BIDL_N_OUT          4
`define BIDL_N_SLOT         7

`define BIDL_A_CTRL         8'h00
`define BIDL_A_STATUS       8'h04
`define BIDL_A_IN_INV       8'h08
`define BIDL_A_BLOCK_SEL    8'h0c
`define BIDL_A_DEB_BASE     8'h10
`define BIDL_A_OUT_BASE     8'h40
`define BIDL_OUT_SEL        2'h0
`define BIDL_OUT_CFG        2'h1
`define BIDL_OUT_TIMES      2'h2

`define BIDL_CFG_CINV       16
`define BIDL_CFG_MODE       17
`define BIDL_CFG_LATCH      18
`define BIDL_CFG_ACKEN      19
`define BIDL_CFG_ACKSEL     20

`define BIDL_RST_TIME       16'h0000
`define BIDL_RST_SEL        28'h0000000
`define BIDL_RST_CFG        24'h000000

`endif

// file: common/bidl_pkg.sv
/*
  Types shared by the binary I/O block.
  Assumes the constants header is compiled alongside.
*/
package bidl_pkg;
  typedef logic [15:0] bidl_time_t;
  typedef logic [3:0]  bidl_sel_t;
  typedef logic [27:0] bidl_slots_t;
  typedef logic [23:0] bidl_cfg_t;
endpackage

// file: hw/bidl_top.sv
/*
  Binary input conditioning and relay output logic with a health relay.
  Assumes synchronous field inputs, a plain register port and one 125 MHz clock.
*/
// The register addresses and the strobed register port were left to the implementer.
`include "bidl_consts.svh"

// Operation
// (R01) New input level accepted at once, timer started
// (R02) Level held while debounce timer runs
// (R03) Per input debounce time and inversion
// (R04) Fixed stabilisation delay before debounce
// (R05) One conditioned input feeds several targets
// (R06) Relay ORs up to seven trigger slots
// (R07) Slot inversion; unassigned slot gives zero
// (R08) Collective inversion; none assigned gives zero
// (R09) Mode selects working or closed-circuit polarity
// (R10) Unlatched relay follows collective state
// (R11) Latched state kept until valid acknowledgement
// (R12) Own acknowledge clears only after triggers dropped
// (R13) Acknowledge ignored until retention delay elapsed
// (R14) Minimum hold time after each level change
// (R15) Latch clear sources after triggers dropped
// (R16) Restart keeps latched outputs
// (R17) Global and SCADA ack need remote enable
// (R18) Health relay picks up only when fault-free
// (R19) Health relay dropped during boot, indicator too
// (R20) Timers count a common tick, programmable terminals
module bidl_top #(
  parameter int TICK_CYC = `BIDL_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  output      logic [31:0] rd_data,
  input  wire logic [7:0]  field_input,
  input  wire logic [7:0]  trig_in,
  input  wire logic        panel_ack,
  input  wire logic        scada_ack,
  input  wire logic        global_output_ack,
  input  wire logic        restart,
  input  wire logic        boot_done,
  input  wire logic        internal_fault,
  output      logic [7:0]  input_level,
  output      logic        external_block_input,
  output      logic [3:0]  relay_output,
  output      logic        health_relay,
  output      logic        health_led
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release and common tick

  logic        rst_meta;
  logic        rst_s;
  logic [16:0] tick_cnt;
  logic        tick;

  // Reset enters at once but leaves in step with the clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_s    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_s    <= rst_meta;
    end
  end

  // The tick counter is 17 bits wide, so TICK_CYC may not exceed 131072
  wire tick_wrap = (tick_cnt == 17'(TICK_CYC - 1));

  // Every timer steps on this one tick, so all share a time base
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      tick_cnt <= 17'h00000;
      tick     <= 1'b0;
    end else if (ce) begin
      tick_cnt <= tick_wrap ? 17'h00000 : tick_cnt + 17'h00001;
      tick     <= tick_wrap; // (R20)
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  logic                remote_ack_en;
  logic [7:0]          in_inv;
  logic [3:0]          block_sel;
  bidl_pkg::bidl_time_t  deb_time [8];
  bidl_pkg::bidl_slots_t out_sel  [4];
  bidl_pkg::bidl_cfg_t   out_cfg  [4];
  bidl_pkg::bidl_time_t  out_ret  [4];
  bidl_pkg::bidl_time_t  out_hold [4];

  wire        hit_ctrl  = (addr == `BIDL_A_CTRL);
  wire        hit_stat  = (addr == `BIDL_A_STATUS);
  wire        hit_inv   = (addr == `BIDL_A_IN_INV);
  wire        hit_blk   = (addr == `BIDL_A_BLOCK_SEL);
  // Eight debounce words from the base; lower addresses wrap far out of range
  wire [7:0]  deb_off   = addr - `BIDL_A_DEB_BASE;
  wire        hit_deb   = (deb_off[7:5] == 3'h0) && (deb_off[1:0] == 2'h0);
  wire [2:0]  deb_idx   = deb_off[4:2];
  wire        hit_out   = (addr[7:6] == 2'h1) && (addr[1:0] == 2'h0);
  wire [1:0]  out_idx   = addr[5:4];
  wire [1:0]  out_fld   = addr[3:2];

  // Writes to unmapped or read-only words fall through unheard
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      remote_ack_en <= 1'b0;
      in_inv        <= 8'h00;
      block_sel     <= 4'h0;
    end else if (ce && wr_strobe) begin
      if (hit_ctrl) begin
        remote_ack_en <= wr_data[0];
      end
      if (hit_inv) begin
        in_inv <= wr_data[7:0]; // (R03)
      end
      if (hit_blk) begin
        block_sel <= wr_data[3:0];
      end
    end
  end

  // One process for the debounce array and one for all four output arrays keep a single driver on every register
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      for (int i = 0; i < `BIDL_N_IN; i++) begin
        deb_time[i] <= `BIDL_RST_TIME;
      end
    end else if (ce && wr_strobe && hit_deb) begin
      deb_time[deb_idx] <= wr_data[15:0]; // (R03)
    end
  end

  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      for (int k = 0; k < `BIDL_N_OUT; k++) begin
        out_sel[k]  <= `BIDL_RST_SEL;
        out_cfg[k]  <= `BIDL_RST_CFG;
        out_ret[k]  <= `BIDL_RST_TIME;
        out_hold[k] <= `BIDL_RST_TIME;
      end
    end else if (ce && wr_strobe && hit_out) begin
      if (out_fld == `BIDL_OUT_SEL) begin
        out_sel[out_idx] <= wr_data[27:0];
      end else if (out_fld == `BIDL_OUT_CFG) begin
        out_cfg[out_idx] <= wr_data[23:0];
      end else if (out_fld == `BIDL_OUT_TIMES) begin
        out_ret[out_idx]  <= wr_data[15:0];
        out_hold[out_idx] <= wr_data[31:16];
      end
    end
  end

  genvar gi;

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] rd_mux;

  wire [31:0] rd_ctrl  = {31'h00000000, remote_ack_en};
  wire [31:0] rd_stat  = {19'h00000, health_relay, relay_output, input_level};
  wire [31:0] rd_inv   = {24'h000000, in_inv};
  wire [31:0] rd_blk   = {28'h0000000, block_sel};
  wire [31:0] rd_deb   = {16'h0000, deb_time[deb_idx]};
  wire [31:0] rd_sel   = {4'h0, out_sel[out_idx]};
  wire [31:0] rd_cfg   = {8'h00, out_cfg[out_idx]};
  wire [31:0] rd_times = {out_hold[out_idx], out_ret[out_idx]};

  // Unmapped addresses answer zero; reads have no side effects
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_ctrl) begin
      rd_mux = rd_ctrl;
    end else if (hit_stat) begin
      rd_mux = rd_stat;
    end else if (hit_inv) begin
      rd_mux = rd_inv;
    end else if (hit_blk) begin
      rd_mux = rd_blk;
    end else if (hit_deb) begin
      rd_mux = rd_deb;
    end else if (hit_out && out_fld == `BIDL_OUT_SEL) begin
      rd_mux = rd_sel;
    end else if (hit_out && out_fld == `BIDL_OUT_CFG) begin
      rd_mux = rd_cfg;
    end else if (hit_out && out_fld == `BIDL_OUT_TIMES) begin
      rd_mux = rd_times;
    end
  end

  // Read data stand for one cycle and are zero otherwise
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      rd_data <= 32'h00000000;
    end else if (ce) begin
      rd_data <= rd_strobe ? rd_mux : 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input conditioning

  generate
    for (gi = 0; gi < `BIDL_N_IN; gi++) begin : g_in
      logic       stab_lvl;
      logic [3:0] stab_cnt;
      logic       acc;
      logic [15:0] deb_cnt;
      logic       lvl_q;
      wire        stab_diff = (field_input[gi] != stab_lvl);
      wire        deb_idle  = (deb_cnt == 16'h0000);
      wire        take      = deb_idle && (stab_lvl != acc);

      // A glitch shorter than the stabilisation window never reaches the debouncer
      always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
          stab_lvl <= 1'b0;
          stab_cnt <= 4'h0;
        end else if (ce) begin
          // Restart throws away a half-counted change
          if (restart || !stab_diff) begin
            stab_cnt <= 4'h0;
          end else if (tick && stab_cnt == `BIDL_STAB_TICKS - 4'h1) begin
            stab_lvl <= field_input[gi]; // (R04)
            stab_cnt <= 4'h0;
          end else if (tick) begin
            stab_cnt <= stab_cnt + 4'h1; // (R04)
          end
        end
      end

      // Zero debounce time lets every stabilised change straight through
      always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
          acc     <= 1'b0;
          deb_cnt <= 16'h0000;
          lvl_q   <= 1'b0;
        end else if (ce) begin
          if (restart) begin
            deb_cnt <= 16'h0000;
          end else if (take) begin
            acc     <= stab_lvl;     // (R01)
            deb_cnt <= deb_time[gi]; // (R01)
          end else if (tick && !deb_idle) begin
            deb_cnt <= deb_cnt - 16'h0001; // (R02) (R20)
          end
          // Inversion follows the debouncer, so timing ignores polarity
          lvl_q <= (take ? stab_lvl : acc) ^ in_inv[gi]; // (R01) (R03)
        end
      end

      assign input_level[gi] = lvl_q;
    end
  endgenerate

  // Same conditioned level also feeds the trigger sources below
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      external_block_input <= 1'b0;
    end else if (ce) begin
      external_block_input <= block_sel[3] & input_level[block_sel[2:0]]; // (R05)
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Relay outputs

  // Sources 0 to 7 are conditioned inputs, 8 to 15 external triggers
  wire [15:0] src        = {trig_in, input_level}; // (R05)
  wire        remote_ack = remote_ack_en && (scada_ack || global_output_ack); // (R17)
  wire        all_ack    = panel_ack || remote_ack; // (R15)

  generate
    for (gi = 0; gi < `BIDL_N_OUT; gi++) begin : g_out
      logic [6:0]  slot_val;
      logic        latched;
      logic        state;
      logic        rly_q;
      logic [15:0] ret_cnt;
      logic [15:0] hold_cnt;
      wire [6:0]   asg      = out_cfg[gi][6:0];
      wire [6:0]   sinv     = out_cfg[gi][14:8];
      wire         cinv     = out_cfg[gi][`BIDL_CFG_CINV];
      wire         mode     = out_cfg[gi][`BIDL_CFG_MODE];
      wire         latch_en = out_cfg[gi][`BIDL_CFG_LATCH];
      wire         ack_en   = out_cfg[gi][`BIDL_CFG_ACKEN];
      wire [3:0]   ack_sel  = out_cfg[gi][`BIDL_CFG_ACKSEL +: 4];
      wire         any_asg  = |asg;
      wire         coll     = any_asg & ((|slot_val) ^ cinv); // (R06) (R08)
      // Acknowledge waits for triggers gone and retention spent
      wire         ret_done = !coll && (ret_cnt >= out_ret[gi]); // (R13)
      wire         own_ack  = latch_en && ack_en && src[ack_sel]; // (R12)
      wire         ack_ok   = ret_done && (own_ack || all_ack); // (R12) (R13)
      wire         want     = latch_en ? (coll || latched) : coll; // (R10) (R11)
      // Hold time starts again at every change of the contact
      wire         hold_ok  = (hold_cnt >= out_hold[gi]);
      wire         next_state = (want != state && hold_ok) ? want : state; // (R14)

      genvar gj;
      for (gj = 0; gj < `BIDL_N_SLOT; gj++) begin : g_slot
        assign slot_val[gj] = asg[gj] & (src[out_sel[gi][4*gj +: 4]] ^ sinv[gj]); // (R07)
      end

      // Restart never touches this flop; reset, latching off, no slot assigned or an accepted acknowledgement clears it
      // A new trigger outranks an acknowledgement in the same cycle
      always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
          latched <= 1'b0;
        end else if (ce) begin
          if (!latch_en || !any_asg) begin
            latched <= 1'b0; // (R15)
          end else if (coll) begin
            latched <= 1'b1; // (R11)
          end else if (ack_ok) begin
            latched <= 1'b0; // (R15)
          end
        end
      end // (R16)

      // Both counters saturate, so a long-idle relay may move at once
      // Closed-circuit mode is a plain inversion of the contact drive
      always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
          ret_cnt  <= 16'h0000;
          hold_cnt <= 16'h0000;
          state    <= 1'b0;
          rly_q    <= 1'b0;
        end else if (ce) begin
          if (restart || coll) begin
            ret_cnt <= 16'h0000;
          end else if (tick && ret_cnt < out_ret[gi]) begin
            ret_cnt <= ret_cnt + 16'h0001; // (R20)
          end
          if (restart || next_state != state) begin
            hold_cnt <= 16'h0000;
          end else if (tick && !hold_ok) begin
            hold_cnt <= hold_cnt + 16'h0001; // (R20)
          end
          state <= restart ? 1'b0 : next_state;
          rly_q <= (restart ? 1'b0 : next_state) ^ mode; // (R09)
        end
      end

      assign relay_output[gi] = rly_q;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Health relay

  // A restart drops the health relay just as a boot does
  wire healthy = boot_done && !internal_fault && !restart;

  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      health_relay <= 1'b0;
      health_led   <= 1'b0;
    end else if (ce) begin
      health_relay <= healthy; // (R18) (R19)
      health_led   <= healthy; // (R19)
    end
  end

endmodule

// file: tb/bidl_sva.sv
/*
  Port-level checker of the binary I/O block.
  Assumes ce held high and registers written only through the port.
*/
module bidl_sva #(
  parameter int TICK_CYC = 4
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_strobe,
  input wire logic [7:0]  field_input,
  input wire logic        restart,
  input wire logic        boot_done,
  input wire logic        internal_fault,
  input wire logic [7:0]  input_level,
  input wire logic        external_block_input,
  input wire logic [3:0]  relay_output,
  input wire logic        health_relay,
  input wire logic        health_led
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  rcnt;
  logic [1:0]  qcnt;
  logic [15:0] hold0;
  logic [3:0]  blk;
  int          fstab;
  int          rchg;
  wire         rdy   = rcnt == 2'h3;
  wire         quiet = qcnt == 2'h3;
  ////////////////////////////////////////
  // Quiet means no write or restart lately, whose effects bypass the timers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt  <= 2'h0;
      qcnt  <= 2'h0;
      hold0 <= 16'h0;
      blk   <= 4'h0;
      fstab <= 0;
      rchg  <= 0;
    end else begin
      rcnt  <= rcnt + {1'b0, !rdy};
      qcnt  <= (wr_strobe || restart) ? 2'h0 : qcnt + {1'b0, !quiet};
      fstab <= $changed(field_input) ? 0 : fstab + 1;
      rchg  <= $changed(relay_output[0]) ? 0 : rchg + 1;
      if (wr_strobe && addr == 8'h48)
        hold0 <= wr_data[31:16];
      if (wr_strobe && addr == 8'h0c)
        blk <= wr_data[3:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_health_fault: assert property (internal_fault |=> !health_relay)
    else $error("health relay up during fault");
  a_health_boot: assert property (!boot_done |=> !health_relay)
    else $error("health relay up during boot");
  a_health_up: assert property (rdy && boot_done && !internal_fault && !restart |=> health_relay)
    else $error("health relay not up");
  a_restart_drop: assert property (restart |=> !health_relay)
    else $error("health relay up in restart");
  a_led_follow: assert property (health_led == health_relay)
    else $error("health indicator differs");
  a_stab_delay: assert property (rdy && quiet && $changed(input_level) |-> fstab >= 11 * TICK_CYC)
    else $error("input taken before stabilising");
  a_block_fan: assert property (quiet && $stable(input_level) |->
    external_block_input == (blk[3] && input_level[blk[2:0]]))
    else $error("block input differs");
  a_hold_time: assert property (rdy && quiet && $changed(relay_output[0]) |->
    rchg + TICK_CYC >= int'(hold0) * TICK_CYC)
    else $error("relay changed within hold time");

  c_relay_set: cover property ($rose(relay_output[0]));
  c_health_up: cover property ($rose(health_relay));
  c_block_on: cover property ($rose(external_block_input));
endmodule

bind bidl_top bidl_sva #(.TICK_CYC(TICK_CYC)) sva_u (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
  .field_input(field_input), .restart(restart), .boot_done(boot_done),
  .internal_fault(internal_fault), .input_level(input_level),
  .external_block_input(external_block_input), .relay_output(relay_output),
  .health_relay(health_relay), .health_led(health_led));

// file: tb/bidl_field.sv
/*
  Field wiring of the inputs: contacts that may chatter before settling.
  Assumes the bench sets the wanted level and asks for chatter.
*/
module bidl_field (
  input  wire logic       clk,
  input  wire logic [7:0] level,
  input  wire logic       bounce,
  output      logic [7:0] field_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last = 8'h0;
  logic [7:0] mask = 8'h0;
  logic [2:0] chat = 3'h0;
  initial field_input = 8'h0;
  // Moving bits toggle each cycle, then rest at the wanted level
  always @(posedge clk) begin
    if (level != last) begin
      last        <= level;
      mask        <= level ^ last;
      chat        <= bounce ? 3'h5 : 3'h0;
      field_input <= bounce ? field_input ^ (level ^ last) : level;
    end else if (chat != 3'h0) begin
      chat        <= chat - 3'h1;
      field_input <= (chat == 3'h1) ? level : field_input ^ mask;
    end
  end
endmodule

// file: tb/tb_top.sv
/*
  Self-checking bench of the binary I/O block.
  Assumes the design, field model and checker are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, wr_strobe, rd_strobe, restart, boot_done, internal_fault, bounce;
  logic        panel_ack, scada_ack, global_output_ack, s_hr, s_led, s_blk;
  logic        health_relay, health_led, external_block_input;
  logic [7:0]  addr, trig_in, lev, field_input, input_level, s_in;
  logic [31:0] wr_data, rd_data, s_rd;
  logic [3:0]  relay_output, s_rel;
  int          num_errors, n_tests;
  // Rows of {output config, triggers, expected relay}
  logic [35:0] tab [8] = '{36'h000003021, 36'h000040001, 36'h000003000, 36'h000201000,
                           36'h000101001, 36'h010000000, 36'h010001001, 36'h030001000};

  bidl_top #(.TICK_CYC(4)) dut_u (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .field_input(field_input), .trig_in(trig_in),
    .panel_ack(panel_ack), .scada_ack(scada_ack), .global_output_ack(global_output_ack),
    .restart(restart), .boot_done(boot_done), .internal_fault(internal_fault),
    .input_level(input_level), .external_block_input(external_block_input),
    .relay_output(relay_output), .health_relay(health_relay), .health_led(health_led));
  bidl_field fld_u (.clk(clk), .level(lev), .bounce(bounce), .field_input(field_input));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Outputs are taken at the falling edge, where they are settled
  always @(negedge clk)
    {s_rd, s_in, s_rel, s_hr, s_led, s_blk} <= {rd_data, input_level, relay_output,
                                                health_relay, health_led, external_block_input};
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr      <= a;
    wr_data   <= d;
    wr_strobe <= 1'b1;
    cyc(1);
    wr_strobe <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr      <= a;
    rd_strobe <= 1'b1;
    cyc(1);
    rd_strobe <= 1'b0;
    cyc(1);
    chk(s_rd, e, "rd_data");
  endtask
  task automatic trg(input logic [7:0] v);
    trig_in <= v;
    cyc(6);
  endtask
  // 0 panel, 1 scada, 2 global acknowledge, 3 restart
  task automatic ack(input int k);
    {restart, global_output_ack, scada_ack, panel_ack} <= 4'h1 << k;
    cyc(1);
    {restart, global_output_ack, scada_ack, panel_ack} <= 4'h0;
    cyc(6);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial begin
    {rst_n, wr_strobe, rd_strobe, restart, boot_done, internal_fault, bounce} = 7'h0;
    {panel_ack, scada_ack, global_output_ack, addr, trig_in, lev, wr_data} = 59'h0;
    num_errors = 0;
    n_tests = 0;
    cyc(10);
    rst_n <= 1'b1;
    cyc(4);
    chk(s_hr, 1'h0, "health");
    boot_done <= 1'b1;
    cyc(3);
    chk({s_hr, s_led}, 2'h3, "health");
    internal_fault <= 1'b1;
    cyc(3);
    chk(s_hr, 1'h0, "health");
    internal_fault <= 1'b0;
    $display("health test done");
    wr(8'h10, 32'h28);
    bounce <= 1'b1;
    lev <= 8'h01;
    cyc(40);
    chk(s_in[0], 1'h0, "input");
    cyc(30);
    chk(s_in[0], 1'h1, "input");
    lev <= 8'h00;
    cyc(110);
    chk(s_in[0], 1'h1, "input");
    cyc(60);
    chk(s_in[0], 1'h0, "input");
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h9);
    cyc(3);
    chk({s_blk, s_in}, 9'h102, "inputs");
    rd(8'h04, 32'h1002);
    rd(8'h3c, 32'h0);
    wr(8'h2c, 32'h7);
    rd(8'h2c, 32'h7);
    $display("input test done");
    wr(8'h40, 32'h1000098);
    for (int i = 0; i < 8; i++) begin
      wr(8'h44, {8'h0, tab[i][35:12]});
      trg(tab[i][11:4]);
      chk(s_rel[0], tab[i][3:0], "relay");
    end
    $display("relay test done");
    wr(8'h48, 32'h5);
    wr(8'h44, 32'hac0001);
    trg(8'h01);
    trg(8'h00);
    chk(s_rel[0], 1'h1, "latch");
    trg(8'h04);
    trg(8'h00);
    chk(s_rel[0], 1'h1, "latch");
    ack(3);
    chk(s_rel[0], 1'h1, "latch");
    cyc(24);
    ack(1);
    chk(s_rel[0], 1'h1, "latch");
    trg(8'h04);
    trg(8'h00);
    chk(s_rel[0], 1'h0, "latch");
    wr(8'h00, 32'h1);
    trg(8'h01);
    trg(8'h00);
    cyc(24);
    ack(2);
    chk(s_rel[0], 1'h0, "latch");
    trg(8'h01);
    ack(0);
    chk(s_rel[0], 1'h1, "latch");
    trg(8'h00);
    cyc(24);
    ack(0);
    chk(s_rel[0], 1'h0, "latch");
    trg(8'h01);
    trg(8'h00);
    wr(8'h44, 32'h0c0000);
    cyc(3);
    chk(s_rel[0], 1'h0, "latch");
    $display("latch test done");
    wr(8'h48, 32'ha0000);
    wr(8'h44, 32'h1);
    cyc(44);
    trg(8'h01);
    chk(s_rel[0], 1'h1, "hold");
    trg(8'h00);
    chk(s_rel[0], 1'h1, "hold");
    cyc(44);
    chk(s_rel[0], 1'h0, "hold");
    $display("hold test done");
    conclude();
  end
endmodule
